// File: hdl/sdt_top.sv
`timescale 1ns/1ps
`include "sdt_map.svh"

// Notes on behaviour
// - a positive differential input yields a positive output word and a negative one a negative.
// - each word spans one output period of modulator results fast, two in sinc2, three in sinc3.
// - the decimation ratio only takes values from 20 to 2047.
// - in auto mode a channel change restarts the filter as fast, then sinc2, then sinc3.
// - the modulator runs at the oscillator divided by 128, or by 256 when the divide bit is set.
// - one word is produced per output period, modulator rate over the decimation ratio.
// - sampling switches at the modulator rate for gains 1-8, x2 at 16, x4 at 32, x8 at 64/128.
// - result_ready_n falls on a new word, rises when it is read, and rises before each update.
module sdt_top (
  input logic ref_clk,
  input logic rst,
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic modulatorBit,
  output logic modClkTick,
  output logic sampleSwitchTick,
  output logic [3:0] channelSel,
  output logic resultReady_n,
  output logic irq
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] mergeW(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic ratioOk(input logic [10:0] v);
    return (v >= `SDT_DEC_MIN) && (v <= `SDT_DEC_MAX);
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic awHeld_ff, wHeld_ff, bvalid_ff, rvalid_ff;
  logic [7:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [5:0] ctrl_ff;
  logic [3:0] chan_ff;
  logic [10:0] decim_ff;
  logic [31:0] result_ff, pendVal_ff;
  logic ready_ff, pend_ff;
  logic [1:0] iStat_ff, iMask_ff;
  logic [1:0] perCnt_ff;
  logic [10:0] decCnt_ff;

  // ----------------------------------------
  // write channel decode
  // ----------------------------------------
  logic doWrite, wrCtrl, wrChan, wrDecim, wrIStat, wrIMask, wrHit;
  logic [31:0] ctrlW, chanW, decimW, iStatW, iMaskW;

  assign s_axi_awready = !awHeld_ff && !bvalid_ff;
  assign s_axi_wready = !wHeld_ff && !bvalid_ff;
  assign doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;
  assign wrCtrl = doWrite && (awAddr_ff == `SDT_OFF_CTRL);
  assign wrChan = doWrite && (awAddr_ff == `SDT_OFF_CHAN);
  assign wrDecim = doWrite && (awAddr_ff == `SDT_OFF_DECIM);
  assign wrIStat = doWrite && (awAddr_ff == `SDT_OFF_ISTAT);
  assign wrIMask = doWrite && (awAddr_ff == `SDT_OFF_IMASK);
  // data and status words are read-only; writes there are accepted and dropped
  assign wrHit = wrCtrl || wrChan || wrDecim || wrIStat || wrIMask ||
                 (awAddr_ff == `SDT_OFF_DATA) || (awAddr_ff == `SDT_OFF_STAT);
  assign ctrlW = mergeW({26'h0, ctrl_ff}, wData_ff, wStrb_ff);
  assign chanW = mergeW({28'h0, chan_ff}, wData_ff, wStrb_ff);
  assign decimW = mergeW({21'h0, decim_ff}, wData_ff, wStrb_ff);
  assign iStatW = mergeW(32'h0, wData_ff, wStrb_ff);
  assign iMaskW = mergeW({30'h0, iMask_ff}, wData_ff, wStrb_ff);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= sdt_pkg::SDT_OKAY;
      awAddr_ff <= 8'h00;
      wData_ff <= 32'h0;
      wStrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wrHit ? sdt_pkg::SDT_OKAY : sdt_pkg::SDT_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  sdt_pkg::sdt_mode_t mode;
  logic restart;

  assign mode = sdt_pkg::sdt_mode_t'(ctrl_ff[`SDT_CTRL_MODE_HI:`SDT_CTRL_MODE_LO]);
  // any write to the channel word counts as a new channel selection
  assign restart = wrChan;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_ff <= `SDT_CTRL_RST;
      chan_ff <= `SDT_CHAN_RST;
      decim_ff <= `SDT_DECIM_RST;
      iMask_ff <= `SDT_IMASK_RST;
    end else begin
      if (wrCtrl) begin
        ctrl_ff <= ctrlW[5:0];
      end
      if (wrChan) begin
        chan_ff <= chanW[3:0];
      end
      // out-of-range ratios leave the previous ratio in place
      if (wrDecim && (decimW[31:11] == 21'h0) && ratioOk(decimW[10:0])) begin
        decim_ff <= decimW[10:0];
      end
      if (wrIMask) begin
        iMask_ff <= iMaskW[1:0];
      end
    end
  end

  assign channelSel = chan_ff;

  // ----------------------------------------
  // rate generation and decimation
  // ----------------------------------------
  logic modTick, decimTick;

  sdt_clkgen u_clkgen (
    .ref_clk(ref_clk),
    .rst(rst),
    .divSel(ctrl_ff[`SDT_CTRL_DIV]),
    .gainCode(ctrl_ff[`SDT_CTRL_GAIN_HI:`SDT_CTRL_GAIN_LO]),
    .modTick(modTick),
    .sampTick(sampleSwitchTick)
  );

  assign modClkTick = modTick;
  // >= rather than == so a smaller ratio written mid-period cannot stall the count
  assign decimTick = modTick && (decCnt_ff >= decim_ff - 11'h001);

  always_ff @(posedge ref_clk) begin
    if (rst || restart) begin
      decCnt_ff <= 11'h000;
    end else if (modTick) begin
      decCnt_ff <= decimTick ? 11'h000 : decCnt_ff + 11'h001;
    end
  end

  // ----------------------------------------
  // filter order selection
  // ----------------------------------------
  logic [1:0] curOrder;
  logic sincValid;
  logic signed [35:0] sincVal;

  assign curOrder = (mode != sdt_pkg::SDT_AUTO) ? mode :
                    (perCnt_ff == 2'h0) ? 2'h1 :
                    (perCnt_ff == 2'h1) ? 2'h2 : 2'h3;

  // counts words since the channel change and parks at two
  always_ff @(posedge ref_clk) begin
    if (rst || restart) begin
      perCnt_ff <= 2'h0;
    end else if (sincValid && (perCnt_ff != 2'h2)) begin
      perCnt_ff <= perCnt_ff + 2'h1;
    end
  end

  sdt_sinc u_sinc (
    .ref_clk(ref_clk),
    .rst(rst),
    .clr(restart),
    .modTick(modTick),
    .decimTick(decimTick),
    .modBit(modulatorBit),
    .order(curOrder),
    .outValid(sincValid),
    .outVal(sincVal)
  );

  // ----------------------------------------
  // result register and ready flag
  // ----------------------------------------
  logic rdHit, rdData, loadRes;

  assign s_axi_arready = !rvalid_ff;
  assign rdHit = s_axi_arvalid && s_axi_arready;
  assign rdData = rdHit && (s_axi_araddr == `SDT_OFF_DATA);
  assign loadRes = pend_ff;

  // a new word first drops the ready flag for a cycle, then lands in the register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_ff <= 1'b0;
      pendVal_ff <= 32'h0;
      result_ff <= 32'h0;
      ready_ff <= 1'b0;
    end else begin
      pend_ff <= sincValid;
      if (sincValid) begin
        pendVal_ff <= sdt_pkg::sdt_sat32(sincVal);
      end
      if (loadRes) begin
        result_ff <= pendVal_ff;
        ready_ff <= 1'b1;
      end else if (sincValid || rdData) begin
        ready_ff <= 1'b0;
      end
    end
  end

  assign resultReady_n = !ready_ff;

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic [1:0] iSet;

  assign iSet[`SDT_IRQ_NEW] = loadRes;
  // overrun: a word replaced while the previous one is still unread
  assign iSet[`SDT_IRQ_OVR] = sincValid && ready_ff;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      iStat_ff <= 2'h0;
    end else begin
      iStat_ff <= (iStat_ff & ~(wrIStat ? iStatW[1:0] : 2'h0)) | iSet;
    end
  end

  assign irq = |(iStat_ff & iMask_ff);

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  logic [31:0] rdMux;
  logic rdMapped;

  assign rdMapped = (s_axi_araddr == `SDT_OFF_CTRL) || (s_axi_araddr == `SDT_OFF_CHAN) ||
                    (s_axi_araddr == `SDT_OFF_DECIM) || (s_axi_araddr == `SDT_OFF_DATA) ||
                    (s_axi_araddr == `SDT_OFF_STAT) || (s_axi_araddr == `SDT_OFF_ISTAT) ||
                    (s_axi_araddr == `SDT_OFF_IMASK);
  assign rdMux = (s_axi_araddr == `SDT_OFF_CTRL) ? {26'h0, ctrl_ff} :
                 (s_axi_araddr == `SDT_OFF_CHAN) ? {28'h0, chan_ff} :
                 (s_axi_araddr == `SDT_OFF_DECIM) ? {21'h0, decim_ff} :
                 (s_axi_araddr == `SDT_OFF_DATA) ? result_ff :
                 (s_axi_araddr == `SDT_OFF_STAT) ? {29'h0, curOrder, ready_ff} :
                 (s_axi_araddr == `SDT_OFF_ISTAT) ? {30'h0, iStat_ff} :
                 (s_axi_araddr == `SDT_OFF_IMASK) ? {30'h0, iMask_ff} : 32'h0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= sdt_pkg::SDT_OKAY;
    end else if (rdHit) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rdMux;
      rresp_ff <= rdMapped ? sdt_pkg::SDT_OKAY : sdt_pkg::SDT_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic signed [35:0] absVal;
  assign absVal = sincVal[35] ? -sincVal : sincVal;

  a_sign_follow: assert property (@(posedge ref_clk) disable iff (rst)
    sincValid |=> pendVal_ff[31] == $past(sincVal[35]))
    else $error("result sign differs from filter sum");

  a_fast_bound: assert property (@(posedge ref_clk) disable iff (rst)
    decimTick && curOrder == 2'h1 && !restart |=> absVal <= {25'h0, decim_ff})
    else $error("fast word spans more than one output period");

  a_ratio_range: assert property (@(posedge ref_clk) disable iff (rst)
    ratioOk(decim_ff))
    else $error("decimation ratio out of range");

  a_auto_first: assert property (@(posedge ref_clk) disable iff (rst)
    restart && mode == sdt_pkg::SDT_AUTO && !wrCtrl |=> curOrder == 2'h1 ##1 perCnt_ff == 2'h0)
    else $error("auto mode did not restart with fast settling");

  a_decim_tick: assert property (@(posedge ref_clk) disable iff (rst)
    decimTick && !restart |-> modTick ##1 (sincValid && decCnt_ff == 11'h000))
    else $error("output word not tied to decimation count");

  a_ready_before: assert property (@(posedge ref_clk) disable iff (rst)
    sincValid |=> resultReady_n && result_ff == $past(result_ff) ##1 !resultReady_n)
    else $error("ready not high before result update");

  a_ready_read: assert property (@(posedge ref_clk) disable iff (rst)
    rdData && !loadRes |=> resultReady_n)
    else $error("ready not released after data read");

  a_auto_hold: assert property (@(posedge ref_clk) disable iff (rst)
    mode == sdt_pkg::SDT_AUTO && perCnt_ff == 2'h2 && !restart && !wrCtrl |=> curOrder == 2'h3)
    else $error("auto mode left sinc3 without a channel change");

endmodule

// File: hdl/sdt_map.svh
`ifndef SDT_MAP_SVH
`define SDT_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SDT_OFF_CTRL 8'h00
`define SDT_OFF_CHAN 8'h04
`define SDT_OFF_DECIM 8'h08
`define SDT_OFF_DATA 8'h0c
`define SDT_OFF_STAT 8'h10
`define SDT_OFF_ISTAT 8'h14
`define SDT_OFF_IMASK 8'h18

// ----------------------------------------
// control fields
// ----------------------------------------
`define SDT_CTRL_DIV 0
`define SDT_CTRL_MODE_LO 1
`define SDT_CTRL_MODE_HI 2
`define SDT_CTRL_GAIN_LO 3
`define SDT_CTRL_GAIN_HI 5

// ----------------------------------------
// status and interrupt fields
// ----------------------------------------
`define SDT_STAT_READY 0
`define SDT_STAT_ORD_LO 1
`define SDT_STAT_ORD_HI 2
`define SDT_IRQ_NEW 0
`define SDT_IRQ_OVR 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define SDT_CTRL_RST 6'h00
`define SDT_CHAN_RST 4'h0
`define SDT_DECIM_RST 11'h014
`define SDT_IMASK_RST 2'h0

// ----------------------------------------
// counts
// ----------------------------------------
`define SDT_DEC_MIN 11'h014
`define SDT_DEC_MAX 11'h7ff
// last count of a 128 and a 256 cycle modulator period
`define SDT_MF0_LAST 8'h7f
`define SDT_MF1_LAST 8'hff

`endif

// File: hdl/sdt_pkg.sv
package sdt_pkg;

  typedef enum logic [1:0] {
    SDT_AUTO  = 2'b00,
    SDT_FAST  = 2'b01,
    SDT_SINC2 = 2'b10,
    SDT_SINC3 = 2'b11
  } sdt_mode_t;

  typedef enum logic [1:0] {
    SDT_OKAY   = 2'b00,
    SDT_SLVERR = 2'b10
  } sdt_resp_t;

  // clip the wide filter sum into a 32-bit signed word, keeping its sign
  function automatic logic [31:0] sdt_sat32(input logic signed [35:0] v);
    logic hiSame;
    hiSame = (v[35:31] == 5'h00) || (v[35:31] == 5'h1f);
    if (hiSame) begin
      return v[31:0];
    end
    return v[35] ? 32'h80000000 : 32'h7fffffff;
  endfunction

endpackage

// File: hdl/sdt_clkgen.sv
`timescale 1ns/1ps
`include "sdt_map.svh"

module sdt_clkgen (
  input logic ref_clk,
  input logic rst,
  input logic divSel,
  input logic [2:0] gainCode,
  output logic modTick,
  output logic sampTick
);

  logic [7:0] cnt_ff;
  logic [7:0] lastCnt;
  logic [1:0] shiftAmt;
  logic [7:0] sampMask;

  // ----------------------------------------
  // modulator and sampling strobes
  // ----------------------------------------
  assign lastCnt = divSel ? `SDT_MF1_LAST : `SDT_MF0_LAST;
  // gains 1..8 -> x1, 16 -> x2, 32 -> x4, 64 and 128 -> x8
  assign shiftAmt = (gainCode < 3'h4) ? 2'h0 :
                    (gainCode == 3'h4) ? 2'h1 :
                    (gainCode == 3'h5) ? 2'h2 : 2'h3;
  assign sampMask = lastCnt >> shiftAmt;
  assign modTick = (cnt_ff == lastCnt);
  assign sampTick = ((cnt_ff & sampMask) == sampMask);

  // a shrinking divide can leave cnt above lastCnt; it then wraps at 255
  always_ff @(posedge ref_clk) begin
    if (rst || modTick) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // ----------------------------------------
  // spacing monitors
  // ----------------------------------------
  logic [7:0] gap_ff;
  logic [7:0] sGap_ff;
  logic gapOk_ff;
  logic sOk_ff;
  logic divD_ff;
  logic [2:0] gainD_ff;
  logic cfgChg;

  assign cfgChg = (divD_ff != divSel) || (gainD_ff != gainCode);

  always_ff @(posedge ref_clk) begin
    divD_ff <= divSel;
    gainD_ff <= gainCode;
    gap_ff <= modTick ? 8'h00 : gap_ff + 8'h01;
    sGap_ff <= sampTick ? 8'h00 : sGap_ff + 8'h01;
    if (rst || cfgChg) begin
      gapOk_ff <= 1'b0;
      sOk_ff <= 1'b0;
    end else begin
      gapOk_ff <= gapOk_ff | modTick;
      sOk_ff <= sOk_ff | sampTick;
    end
  end

  a_mod_divide: assert property (@(posedge ref_clk) disable iff (rst)
    modTick && gapOk_ff && !cfgChg |-> gap_ff == lastCnt)
    else $error("modulator strobe spacing wrong");

  a_samp_rate: assert property (@(posedge ref_clk) disable iff (rst)
    sampTick && sOk_ff && !cfgChg |-> sGap_ff == sampMask)
    else $error("sampling strobe spacing wrong");

endmodule

// File: hdl/sdt_sinc.sv
`timescale 1ns/1ps

module sdt_sinc (
  input logic ref_clk,
  input logic rst,
  input logic clr,
  input logic modTick,
  input logic decimTick,
  input logic modBit,
  input logic [1:0] order,
  output logic outValid,
  output logic signed [35:0] outVal
);

  logic signed [35:0] x;
  logic signed [35:0] i1_ff, i2_ff, i3_ff;
  logic signed [35:0] h1_ff, h2a_ff, h2b_ff, h3a_ff, h3b_ff, h3c_ff;
  logic signed [35:0] y1, y2, y3, ySel;
  logic signed [35:0] nxt_i1, nxt_i2, nxt_i3;

  // ----------------------------------------
  // integrate at modulator rate, comb at output rate
  // ----------------------------------------
  // a one maps to +1 so a positive input drives the sum upward
  assign x = modBit ? 36'sh000000001 : 36'shfffffffff;
  // comb depth equals the order: 1, 2 or 3 output periods of history
  // the comb reads the integrators as this tick leaves them, so the strobe's own sample
  // closes the period and the first word after a clear spans a whole period
  assign nxt_i1 = modTick ? i1_ff + x : i1_ff;
  assign nxt_i2 = modTick ? i2_ff + i1_ff : i2_ff;
  assign nxt_i3 = modTick ? i3_ff + i2_ff : i3_ff;
  assign y1 = nxt_i1 - h1_ff;
  assign y2 = nxt_i2 - (h2a_ff <<< 1) + h2b_ff;
  assign y3 = nxt_i3 - (h3a_ff <<< 1) - h3a_ff + (h3b_ff <<< 1) + h3b_ff - h3c_ff;
  assign ySel = (order == 2'h1) ? y1 : (order == 2'h2) ? y2 : y3;

  // wraparound sums are exact as long as 36 bits hold the sinc3 peak
  always_ff @(posedge ref_clk) begin
    if (rst || clr) begin
      {i1_ff, i2_ff, i3_ff, h1_ff} <= '0;
      {h2a_ff, h2b_ff, h3a_ff, h3b_ff, h3c_ff} <= '0;
      outValid <= 1'b0;
      outVal <= '0;
    end else begin
      i1_ff <= nxt_i1;
      i2_ff <= nxt_i2;
      i3_ff <= nxt_i3;
      if (decimTick) begin
        h1_ff <= nxt_i1;
        {h2b_ff, h2a_ff} <= {h2a_ff, nxt_i2};
        {h3c_ff, h3b_ff, h3a_ff} <= {h3b_ff, h3a_ff, nxt_i3};
        outVal <= ySel;
      end
      outValid <= decimTick;
    end
  end

  a_comb_strobe: assert property (@(posedge ref_clk) disable iff (rst || clr)
    decimTick |=> outValid ##1 !outValid)
    else $error("filter output strobe not one cycle after decimation");

endmodule

// File: tb/sdt_mod_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// modulator stream source
// ----------------------------------------
module sdt_mod_model (
  input logic ref_clk,
  input logic modClkTick,
  input logic level,
  output logic modulatorBit
);
  logic toggle_ff = 1'b0;

  // off-tick cycles carry a toggling pattern so a mistimed sample shows up
  always_ff @(posedge ref_clk) begin
    toggle_ff <= ~toggle_ff;
  end

  assign modulatorBit = modClkTick ? level : toggle_ff;
endmodule

// File: tb/sinc_decimation_timing_tb_top.sv
`timescale 1ns/1ps
`include "sdt_map.svh"

module sinc_decimation_timing_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic modulatorBit, modClkTick, sampleSwitchTick, resultReady_n, irq;
  logic [3:0] channelSel;
  logic level = 1'b1;
  logic [31:0] rd;
  int errCount = 0;
  int nTests = 0;
  int cyc = 0;

  always #5 ref_clk = ~ref_clk;

  sdt_top dut (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .modulatorBit(modulatorBit),
    .modClkTick(modClkTick), .sampleSwitchTick(sampleSwitchTick),
    .channelSel(channelSel), .resultReady_n(resultReady_n), .irq(irq));

  sdt_mod_model modSrc (.ref_clk(ref_clk), .modClkTick(modClkTick), .level(level),
    .modulatorBit(modulatorBit));

  // ----------------------------------------
  // report and compare
  // ----------------------------------------
  task automatic finalReport();
    $display("checks %0d errors %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // the ceiling covers all scenarios with ample margin
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errCount++;
      finalReport();
    end
  end

  task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chkBit(input string nm, input logic exp, input logic got);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk32("bresp", 32'(er), 32'(s_axi_bresp));
  endtask

  task automatic axiRd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    chk32("rresp", 32'(er), 32'(s_axi_rresp));
  endtask

  // no local limit: a word that never comes is caught by the cycle ceiling
  task automatic waitLvl(input logic v, output int t);
    do begin
      @(posedge ref_clk);
    end while (resultReady_n !== v);
    t = cyc;
  endtask

  // first gaps after a setting change may be partial, so only the third counts
  task automatic tickGap(input logic s, output int g);
    int k;
    repeat (3) begin
      k = 0;
      do begin
        @(posedge ref_clk);
        k++;
      end while (!(s ? sampleSwitchTick : modClkTick) && k < 2000);
      g = k;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic tReset();
    chkBit("rdyRst", 1'b1, resultReady_n);
    chkBit("irqRst", 1'b0, irq);
    axiRd(`SDT_OFF_CTRL, rd, 2'b00);
    chk32("ctrlRst", 32'h0, rd);
    axiRd(`SDT_OFF_DECIM, rd, 2'b00);
    chk32("decimRst", 32'h14, rd);
    axiRd(`SDT_OFF_IMASK, rd, 2'b00);
    chk32("imaskRst", 32'h0, rd);
    axiRd(8'h1c, rd, 2'b10);
    chk32("unmapped", 32'h0, rd);
    axiWr(8'h1c, 32'h1, 2'b10);
  endtask

  task automatic tTicks();
    int g, e;
    for (int dv = 0; dv < 2; dv++) begin
      for (int c = 0; c < 8; c++) begin
        axiWr(`SDT_OFF_CTRL, 32'((c << 3) | dv), 2'b00);
        tickGap(1'b0, g);
        chk32("modGap", 32'(128 << dv), 32'(g));
        tickGap(1'b1, g);
        e = (128 << dv) >> (c < 4 ? 0 : (c > 6 ? 3 : c - 3));
        chk32("sampGap", 32'(e), 32'(g));
      end
    end
  endtask

  task automatic tDecim();
    logic [31:0] wv[4] = '{32'd19, 32'd2047, 32'd2048, 32'd20};
    logic [31:0] ev[4] = '{32'd20, 32'd2047, 32'd2047, 32'd20};
    for (int i = 0; i < 4; i++) begin
      axiWr(`SDT_OFF_DECIM, wv[i], 2'b00);
      axiRd(`SDT_OFF_DECIM, rd, 2'b00);
      chk32("decim", ev[i], rd);
    end
  endtask

  task automatic tRate();
    int f1, r, f2;
    axiWr(`SDT_OFF_CTRL, 32'h2, 2'b00);
    axiWr(`SDT_OFF_CHAN, 32'h5, 2'b00);
    chk32("chan", 32'h5, 32'(channelSel));
    axiRd(`SDT_OFF_DATA, rd, 2'b00);
    axiWr(`SDT_OFF_ISTAT, 32'h3, 2'b00);
    waitLvl(1'b0, f1);
    waitLvl(1'b1, r);
    waitLvl(1'b0, f2);
    chk32("wordGap", 32'(20 * 128), 32'(f2 - f1));
    chk32("preUpdate", 32'd1, 32'(f2 - r));
    axiRd(`SDT_OFF_ISTAT, rd, 2'b00);
    chk32("istat", 32'h3, rd);
    chkBit("irqMasked", 1'b0, irq);
    axiWr(`SDT_OFF_IMASK, 32'h2, 2'b00);
    chkBit("irqOn", 1'b1, irq);
    axiRd(`SDT_OFF_DATA, rd, 2'b00);
    chk32("dataPos", 32'd20, rd);
    chkBit("rdyAfterRead", 1'b1, resultReady_n);
    axiWr(`SDT_OFF_ISTAT, 32'h2, 2'b00);
    chkBit("irqOff", 1'b0, irq);
    axiRd(`SDT_OFF_ISTAT, rd, 2'b00);
    chk32("istatW1c", 32'h1, rd);
  endtask

  task automatic tNeg();
    int t;
    level <= 1'b0;
    axiWr(`SDT_OFF_CHAN, 32'h2, 2'b00);
    axiRd(`SDT_OFF_DATA, rd, 2'b00);
    waitLvl(1'b0, t);
    axiRd(`SDT_OFF_DATA, rd, 2'b00);
    chk32("dataNeg", 32'hffffffec, rd);
    level <= 1'b1;
  endtask

  task automatic tAuto();
    int t;
    logic [31:0] ev[4] = '{32'd20, 32'd400, 32'd8000, 32'd8000};
    // order in use once each word is read: sinc2 after the fast word, then sinc3
    logic [31:0] so[4] = '{32'h4, 32'h6, 32'h6, 32'h6};
    axiWr(`SDT_OFF_CTRL, 32'h0, 2'b00);
    axiWr(`SDT_OFF_CHAN, 32'h7, 2'b00);
    axiRd(`SDT_OFF_DATA, rd, 2'b00);
    for (int k = 0; k < 4; k++) begin
      waitLvl(1'b0, t);
      axiRd(`SDT_OFF_DATA, rd, 2'b00);
      chk32("autoWord", ev[k], rd);
      axiRd(`SDT_OFF_STAT, rd, 2'b00);
      chk32("autoOrder", so[k], rd);
    end
    // fixed sinc2 and sinc3 settings override the auto sequence
    for (int m = 2; m < 4; m++) begin
      axiWr(`SDT_OFF_CTRL, 32'(m << 1), 2'b00);
      axiRd(`SDT_OFF_STAT, rd, 2'b00);
      chk32("fixedOrder", 32'(m << 1), rd & 32'h6);
    end
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    tReset();
    tTicks();
    tDecim();
    tRate();
    tNeg();
    tAuto();
    finalReport();
  end
endmodule
